// File: shared/sdp_pkg.sv
// constants for the step distance pulse scaler
package sdp_pkg;
  // ----------------------------------------
  // pin map of the synchronised input vector
  // ----------------------------------------
  localparam int PIN_W = 4;
  localparam int PIN_REF = 0;
  localparam int PIN_LO = 1;
  localparam int PIN_HI = 2;
  localparam int PIN_FC = 3;
  localparam int SYNC_STAGES = 3;
  // ----------------------------------------
  // clock division and scaling
  // ----------------------------------------
  localparam int REF_HZ = 80000;
  localparam int TICK_DIV = 4;
  localparam int TICK_HZ = REF_HZ / TICK_DIV;
  localparam int DIV_A = 10;
  localparam int DIV_A_W = 4;
  localparam int DIV_B = 128;
  localparam int DIV_B_W = 7;
  // ----------------------------------------
  // timing, counted in 20 kHz ticks
  // ----------------------------------------
  localparam int DELAY_MS = 90;
  localparam int DRIVE_MS = 33;
  localparam int DELAY_TICKS = DELAY_MS * TICK_HZ / 1000;
  localparam int DRIVE_TICKS = DRIVE_MS * TICK_HZ / 1000;
  localparam int CNT_W = 11;
  localparam int DRV_W = 10;
  typedef enum logic {SDP_DRV_IDLE, SDP_DRV_ON} sdp_drv_t;
endpackage

// File: test/sdp_far_side.sv
// far side model: reference source, threshold pins, counter readout
module sdp_far_side #(
  parameter int REF_HALF = 3
) (
  input wire logic i_mclk,
  input wire logic i_clk20k,
  input wire logic i_scaled,
  input wire logic i_drive,
  output logic o_ref80k,
  output logic o_lo_thr,
  output logic o_hi_thr,
  output logic o_foot_cross
);
  timeunit 1ns;
  timeprecision 1ns;
  int ticks = 0;
  int g_open = 0;
  int n_sc = 0;
  int n_dr = 0;
  int ph = 0;
  int stalls = 0;
  int sc_t[4];
  int dr_r[4];
  int dr_f[4];
  logic clk_q = 1'b0;
  logic drv_q = 1'b0;
  initial begin
    o_ref80k = 1'b0;
    o_lo_thr = 1'b0;
    o_hi_thr = 1'b1;
    o_foot_cross = 1'b0;
  end
  // reference runs fast so a metre fits the run
  always @(negedge i_mclk) begin
    ph <= (ph == REF_HALF - 1) ? 0 : ph + 1;
    if (ph == REF_HALF - 1) o_ref80k <= ~o_ref80k;
  end
  // readout log, ticks counted on 20 kHz rises
  always @(posedge i_mclk) begin
    clk_q <= i_clk20k;
    drv_q <= i_drive;
    if (i_clk20k === 1'b1 && clk_q === 1'b0) ticks <= ticks + 1;
    if (i_scaled === 1'b1 && n_sc < 4) begin
      sc_t[n_sc] <= ticks;
      n_sc <= n_sc + 1;
    end
    if (i_drive === 1'b1 && drv_q === 1'b0 && n_dr < 4) begin
      dr_r[n_dr] <= ticks;
      n_dr <= n_dr + 1;
    end
    if (i_drive === 1'b0 && drv_q === 1'b1 && n_dr > 0) dr_f[n_dr-1] <= ticks;
  end
  task automatic clear_log;
    n_sc = 0;
    n_dr = 0;
  endtask
  task automatic set_pins(input logic fc, input logic lo, input logic hi);
    @(negedge i_mclk);
    o_foot_cross = fc;
    o_lo_thr = lo;
    o_hi_thr = hi;
  endtask
  task automatic wait_ticks(input int k);
    int t0;
    t0 = ticks;
    for (int i = 0; i < k * 8 * REF_HALF + 8 && ticks - t0 < k; i++)
      @(negedge i_mclk);
    // bound used up: the bench counts it as a mismatch
    if (ticks - t0 < k) stalls++;
  endtask
  // pins change mid-tick so exactly k ticks pass the gate
  task automatic run_step(input int k);
    // processing begins on foot-cross rise
    set_pins(1'b1, 1'b0, 1'b1);
    wait_ticks(1);
    repeat (4 * REF_HALF) @(negedge i_mclk);
    set_pins(1'b1, 1'b1, 1'b1);
    g_open = ticks;
    wait_ticks(k);
    repeat (4 * REF_HALF) @(negedge i_mclk);
    set_pins(1'b1, 1'b1, 1'b0);
    wait_ticks(2);
    set_pins(1'b0, 1'b0, 1'b1);
  endtask
endmodule // sdp_far_side

// File: test/testbench.sv
// self-checking bench for the step distance pulse scaler
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sdp_pkg::*;
  localparam int DLY = 20;
  localparam int DRV = 8;
  localparam int RH = 3;
  logic i_mclk, i_rst_b, i_ref80k, i_lo_thr, i_hi_thr, i_foot_cross;
  logic o_clk20k, o_ramp_holdoff, o_detector_reset;
  logic o_scaled_pulse, o_counter_drive;
  int fails, samples_checked;
  initial i_mclk = 1'b0;
  always #25 i_mclk = ~i_mclk;
  sdp_scaler #(.DELAY_TICKS(DLY), .DRIVE_TICKS(DRV)) dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ref80k(i_ref80k),
    .i_lo_thr(i_lo_thr), .i_hi_thr(i_hi_thr), .i_foot_cross(i_foot_cross),
    .o_clk20k(o_clk20k), .o_ramp_holdoff(o_ramp_holdoff),
    .o_detector_reset(o_detector_reset), .o_scaled_pulse(o_scaled_pulse),
    .o_counter_drive(o_counter_drive));
  sdp_far_side #(.REF_HALF(RH)) far (
    .i_mclk(i_mclk), .i_clk20k(o_clk20k), .i_scaled(o_scaled_pulse),
    .i_drive(o_counter_drive), .o_ref80k(i_ref80k), .o_lo_thr(i_lo_thr),
    .o_hi_thr(i_hi_thr), .o_foot_cross(i_foot_cross));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one tick of slack: async reference phase
  function automatic logic [15:0] near(input int d, input int e);
    return 16'(d >= e - 1 && d <= e + 1);
  endfunction
  task automatic complete_run;
    fails = fails + far.stalls;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic settle(input int n);
    int i;
    for (i = 0; i < 8000 && far.n_dr < n; i++) @(negedge i_mclk);
    if (i == 8000) begin
      fails++;
      complete_run();
    end
    else far.wait_ticks(DLY + DRV + 4);
  endtask
  task automatic test_reset;
    check(16'({o_clk20k, o_ramp_holdoff, o_detector_reset, o_scaled_pulse,
      o_counter_drive}), 16'h0008);
    $display("test reset done");
  endtask
  task automatic test_levels;
    far.set_pins(1'b0, 1'b0, 1'b1);
    repeat (8) @(negedge i_mclk);
    check(16'({o_ramp_holdoff, o_detector_reset}), 16'h0002);
    far.set_pins(1'b1, 1'b0, 1'b0);
    repeat (8) @(negedge i_mclk);
    check(16'({o_ramp_holdoff, o_detector_reset}), 16'h0001);
    // lo rise while hi is low must not open the gate
    far.set_pins(1'b1, 1'b1, 1'b0);
    far.wait_ticks(20);
    far.set_pins(1'b0, 1'b0, 1'b1);
    repeat (8) @(negedge i_mclk);
    check(16'({o_ramp_holdoff, o_detector_reset}), 16'h0002);
    $display("test levels done");
  endtask
  task automatic test_clk20k;
    time t0;
    far.wait_ticks(1);
    t0 = $time;
    far.wait_ticks(1);
    check(16'(($time - t0) / 50), 16'(8 * RH));
    $display("test clk20k done");
  endtask
  task automatic test_long_step;
    far.clear_log();
    far.run_step(2 * DIV_A * DIV_B + 1);
    settle(2);
    check(16'(far.n_sc), 16'h0002);
    check(16'(far.sc_t[1] - far.sc_t[0]), 16'(DIV_A * DIV_B));
    check(near(far.sc_t[0] - far.g_open, DIV_A * DIV_B), 16'h0001);
    check(16'(far.n_dr), 16'h0002);
    for (int j = 0; j < 2; j++) begin
      check(near(far.dr_r[j] - far.sc_t[j], DLY), 16'h0001);
      check(near(far.dr_f[j] - far.dr_r[j], DRV), 16'h0001);
    end
    $display("test long step done");
  endtask
  task automatic test_short_step;
    far.clear_log();
    far.run_step(DIV_A * DIV_B - 1);
    settle(1);
    check(16'(far.n_sc), 16'h0001);
    check(16'(far.n_dr), 16'h0001);
    check(near(far.dr_r[0] - far.sc_t[0], DLY), 16'h0001);
    check(near(far.dr_f[0] - far.dr_r[0], DRV), 16'h0001);
    $display("test short step done");
  endtask
  initial begin
    fails = 0;
    samples_checked = 0;
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_mclk);
    test_reset();
    @(negedge i_mclk);
    i_rst_b = 1'b1;
    test_levels();
    test_clk20k();
    test_long_step();
    test_short_step();
    complete_run();
  end
endmodule // testbench

// File: verilog/sdp_pin_sync.sv
// three-stage pin synchroniser with agreement filter
module sdp_pin_sync #(
  parameter int W = sdp_pkg::PIN_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_q
);
  import sdp_pkg::*;
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // ----------------------------------------
  // per-bit chain
  // ----------------------------------------
  for (genvar g = 0; g < W; g++) begin : g_bit
    // first stage feeds only the second
    always_comb begin
      q_next[g] = q_reg[g];
      if (s2_reg[g] == s3_reg[g]) begin
        q_next[g] = s3_reg[g];
      end
    end
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        s1_reg[g] <= 1'b0;
        s2_reg[g] <= 1'b0;
        s3_reg[g] <= 1'b0;
        q_reg[g] <= 1'b0;
      end else begin
        s1_reg[g] <= i_pin[g];
        s2_reg[g] <= s1_reg[g];
        s3_reg[g] <= s2_reg[g];
        q_reg[g] <= q_next[g];
      end
    end
  end

  assign o_q = q_reg;
endmodule // sdp_pin_sync

// File: verilog/sdp_scaler.sv
// step gate, 1280 scaler, dual delay and counter drive
// Behaviour
// - gate passes 20 kHz only while open
// - divide by ten then by 128
// - one scaled pulse per 1280 gated pulses
// - drive pulse stretched to 33 ms
// - output delayed by fixed 90 ms
// - one or two outputs, matching inputs
// - first timer retriggers, holds until timeout
// - second timer times first pulse only
// - single pulse gives exactly one drive
// - drive triggered by either timer separately
// - detector reset from upper threshold
// - inverted foot-cross releases ramp hold-off
// - same reset clears foot-cross and minimum
// - 20 kHz is 80 kHz divided by four
module sdp_scaler #(
  parameter int DELAY_TICKS = sdp_pkg::DELAY_TICKS,
  parameter int DRIVE_TICKS = sdp_pkg::DRIVE_TICKS
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ref80k,
  input wire logic i_lo_thr,
  input wire logic i_hi_thr,
  input wire logic i_foot_cross,
  output logic o_clk20k,
  output logic o_ramp_holdoff,
  output logic o_detector_reset,
  output logic o_scaled_pulse,
  output logic o_counter_drive
);
  import sdp_pkg::*;
  localparam logic [CNT_W-1:0] DLY_LAST = CNT_W'(DELAY_TICKS - 1);
  localparam logic [DRV_W-1:0] DRV_LAST = DRV_W'(DRIVE_TICKS - 1);
  localparam logic [DIV_A_W-1:0] A_LAST = DIV_A_W'(DIV_A - 1);
  localparam logic [DIV_B_W-1:0] B_LAST = DIV_B_W'(DIV_B - 1);

  logic [PIN_W-1:0] pin_q;
  logic [PIN_W-1:0] prev_reg, prev_next;
  logic [1:0] div4_reg, div4_next;
  logic clk20k_reg, clk20k_next;
  logic gate_reg, gate_next;
  logic holdoff_reg, holdoff_next;
  logic det_rst_reg, det_rst_next;
  logic ref_rise, lo_rise, tick, gated;
  logic [DIV_A_W-1:0] div10_reg, div10_next;
  logic [DIV_B_W-1:0] div128_reg, div128_next;
  logic scaled_reg, scaled_next;
  logic a_run_reg, a_run_next, a_done_reg, a_done_next;
  logic b_run_reg, b_run_next, b_done_reg, b_done_next;
  logic b_used_reg, b_used_next;
  logic [CNT_W-1:0] a_cnt_reg, a_cnt_next, b_cnt_reg, b_cnt_next;
  sdp_drv_t drv_reg, drv_next;
  logic [DRV_W-1:0] drv_cnt_reg, drv_cnt_next;
  logic drive_reg, drive_next;

  sdp_pin_sync #(.W(PIN_W)) u_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_pin({i_foot_cross, i_hi_thr, i_lo_thr, i_ref80k}),
    .o_q(pin_q)
  );

  // ----------------------------------------
  // reference division, gate, analog controls
  // ----------------------------------------
  assign ref_rise = pin_q[PIN_REF] && !prev_reg[PIN_REF];
  assign lo_rise = pin_q[PIN_LO] && !prev_reg[PIN_LO];
  assign tick = ref_rise && (div4_reg == 2'h1);
  // pass ticks only through open gate
  assign gated = tick && gate_reg && pin_q[PIN_HI];

  always_comb begin
    prev_next = pin_q;
    div4_next = div4_reg;
    if (ref_rise) begin
      div4_next = div4_reg + 2'h1;
    end
    clk20k_next = div4_next[1];
    gate_next = gate_reg;
    if (lo_rise && pin_q[PIN_HI]) begin
      gate_next = 1'b1;
    end
    if (!pin_q[PIN_HI]) begin
      gate_next = 1'b0;
    end
    holdoff_next = !pin_q[PIN_FC];
    // reset while upper output is down
    // one reset for flip-flop and minimum
    det_rst_next = !pin_q[PIN_HI];
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_reg <= '0;
      div4_reg <= 2'h0;
      clk20k_reg <= 1'b0;
      gate_reg <= 1'b0;
      holdoff_reg <= 1'b1;
      det_rst_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      div4_reg <= div4_next;
      clk20k_reg <= clk20k_next;
      gate_reg <= gate_next;
      holdoff_reg <= holdoff_next;
      det_rst_reg <= det_rst_next;
    end
  end

  // ----------------------------------------
  // scaler
  // ----------------------------------------
  // residue kept across steps, as ripple counters would
  always_comb begin
    div10_next = div10_reg;
    div128_next = div128_reg;
    scaled_next = 1'b0;
    if (gated) begin
      if (div10_reg == A_LAST) begin
        div10_next = '0;
        div128_next = div128_reg + 1'b1;
        scaled_next = (div128_reg == B_LAST);
      end else begin
        div10_next = div10_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div10_reg <= '0;
      div128_reg <= '0;
      scaled_reg <= 1'b0;
    end else begin
      div10_reg <= div10_next;
      div128_reg <= div128_next;
      scaled_reg <= scaled_next;
    end
  end

  // ----------------------------------------
  // dual delay timers
  // ----------------------------------------
  always_comb begin
    a_run_next = a_run_reg;
    a_cnt_next = a_cnt_reg;
    a_done_next = 1'b0;
    if (scaled_reg) begin
      a_run_next = 1'b1;
      a_cnt_next = '0;
    end else if (a_run_reg && tick) begin
      if (a_cnt_reg == DLY_LAST) begin
        a_run_next = 1'b0;
        a_done_next = 1'b1;
      end else begin
        a_cnt_next = a_cnt_reg + 1'b1;
      end
    end
    b_run_next = b_run_reg;
    b_cnt_next = b_cnt_reg;
    b_done_next = 1'b0;
    b_used_next = b_used_reg;
    if (lo_rise) begin
      b_used_next = 1'b0;
    end
    // timer b takes first pulse only
    if (scaled_reg && !b_run_reg && !b_used_reg) begin
      b_run_next = 1'b1;
      b_cnt_next = '0;
      b_used_next = 1'b1;
    end else if (b_run_reg && tick) begin
      if (b_cnt_reg == DLY_LAST) begin
        b_run_next = 1'b0;
        b_done_next = 1'b1;
      end else begin
        b_cnt_next = b_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_run_reg <= 1'b0;
      a_cnt_reg <= '0;
      a_done_reg <= 1'b0;
      b_run_reg <= 1'b0;
      b_cnt_reg <= '0;
      b_done_reg <= 1'b0;
      b_used_reg <= 1'b0;
    end else begin
      a_run_reg <= a_run_next;
      a_cnt_reg <= a_cnt_next;
      a_done_reg <= a_done_next;
      b_run_reg <= b_run_next;
      b_cnt_reg <= b_cnt_next;
      b_done_reg <= b_done_next;
      b_used_reg <= b_used_next;
    end
  end

  // ----------------------------------------
  // counter drive pulse generator
  // ----------------------------------------
  // not retriggerable: a second trigger inside 33 ms merges
  always_comb begin
    drv_next = drv_reg;
    drv_cnt_next = drv_cnt_reg;
    drive_next = drive_reg;
    unique case (drv_reg)
      SDP_DRV_IDLE: begin
        if (a_done_reg || b_done_reg) begin
          drv_next = SDP_DRV_ON;
          drv_cnt_next = '0;
          drive_next = 1'b1;
        end
      end
      SDP_DRV_ON: begin
        if (tick) begin
          if (drv_cnt_reg == DRV_LAST) begin
            drv_next = SDP_DRV_IDLE;
            drive_next = 1'b0;
          end else begin
            drv_cnt_next = drv_cnt_reg + 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drv_reg <= SDP_DRV_IDLE;
      drv_cnt_reg <= '0;
      drive_reg <= 1'b0;
    end else begin
      drv_reg <= drv_next;
      drv_cnt_reg <= drv_cnt_next;
      drive_reg <= drive_next;
    end
  end

  assign o_clk20k = clk20k_reg;
  assign o_ramp_holdoff = holdoff_reg;
  assign o_detector_reset = det_rst_reg;
  assign o_scaled_pulse = scaled_reg;
  assign o_counter_drive = drive_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  AST_GATE_OPEN: assert property (tick && !(gate_reg && pin_q[PIN_HI])
    |=> $stable(div10_reg))
    else $error("tick counted with gate shut");
  AST_DIV_RANGE: assert property (div10_reg <= A_LAST)
    else $error("decade stage out of range");
  AST_SCALE_WRAP: assert property (scaled_reg |->
    div10_reg == '0 && div128_reg == '0 && $past(gated))
    else $error("scaled pulse not at 1280 wrap");
  AST_DRIVE_END: assert property ($fell(drive_reg) |->
    $past(drv_cnt_reg) == DRV_LAST && $past(tick))
    else $error("drive width wrong");
  AST_B_DONE: assert property (b_done_reg |->
    $past(b_cnt_reg) == DLY_LAST && !b_run_reg)
    else $error("delay end wrong");
  AST_A_RESTART: assert property (scaled_reg |=>
    a_run_reg && a_cnt_reg == '0)
    else $error("timer a not restarted");
  AST_B_NORETRIG: assert property (scaled_reg && b_run_reg && !tick
    |=> b_cnt_reg == $past(b_cnt_reg))
    else $error("timer b retriggered");
  AST_ONE_DRIVE: assert property ((a_done_reg || b_done_reg) &&
    drv_reg == SDP_DRV_IDLE |=> drive_reg ##1 drive_reg)
    else $error("trigger lost");
  AST_HOLDOFF: assert property (holdoff_reg == !$past(pin_q[PIN_FC]))
    else $error("hold-off not inverted foot-cross");
  AST_DET_RST: assert property ($past(i_rst_b) |->
    det_rst_reg == !$past(pin_q[PIN_HI]))
    else $error("detector reset mismatch");
  AST_TICK_DIV: assert property (tick |-> !clk20k_reg ##1 clk20k_reg)
    else $error("20 kHz edge misplaced");

  COV_SCALED: cover property (scaled_reg);
  COV_TWO: cover property (b_done_reg && !a_done_reg ##[1:1000] a_run_reg);
  COV_SINGLE: cover property (a_done_reg && b_done_reg);
  COV_DRIVE: cover property ($fell(drive_reg));
endmodule // sdp_scaler
